//--- pkg/ledfs_pkg.sv
/*
 * Constants for the LED driver fault supervisor.
 * Assumes the supervisor is clocked at the switching rate, with no
 * software-visible registers; configuration arrives as plain pins.
 */
// Functional notes
// - Supply undervoltage halts switching and resets all supervisor logic.
// - Switch current above limit ends the switch pulse for that cycle.
// - Start-up injects current; start waits for switch node above threshold.
// - After start, switch node low while switch off drops protection switch.
// - Sense rising above then falling below 20% drops protection switch.
// - Lower thermal trip marks not-good channels open; disabled after time-out.
// - Open time-out is 800 us above lower threshold, else 6 ms.
// - Output overvoltage: keep current; channels below half time out 6 ms.
// - Upper thermal trip stops switching and all channel sources.
// - Restart when cooled; current steps 77, 53, 30 percent.
// - Every upper thermal trip sets the thermal fault status flag.
// - Status logic stays active through thermal faults unless disabled.
// - Short channel off after 6 ms, 420 us when above lower threshold.
// - Zener-bypassed channel stays enabled unless another fault applies.
// - Healthy channel pushed above short threshold is switched off.
// - A disabled channel leaves the other channels running normally.
// - Lower thermal trip acts on any channel below half target.
// - Start-up short check on switch node; short disables and shuts down. Code waits in LEDFS_CHECK, still injecting.
// - Good at 75 percent; good channel below 50 percent becomes open.
// - Config bit picks short threshold, default high; another disables it.
package ledfs_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned OPEN_SLOW_US   = 6000;
    localparam int unsigned OPEN_FAST_US   = 800;
    localparam int unsigned SHORT_FAST_US  = 420;
    localparam int unsigned OPEN_SLOW_CYC  = OPEN_SLOW_US * CLK_MHZ;
    localparam int unsigned OPEN_FAST_CYC  = OPEN_FAST_US * CLK_MHZ;
    localparam int unsigned SHORT_FAST_CYC = SHORT_FAST_US * CLK_MHZ;
    localparam int unsigned STARTUP_WAIT_CYC = 16;
    localparam logic [7:0]  SCALE_FULL     = 8'hff;
    localparam logic [7:0]  SCALE_STEP1    = 8'hc4;
    localparam logic [7:0]  SCALE_STEP2    = 8'h87;
    localparam logic [7:0]  SCALE_STEP3    = 8'h4d;
    localparam logic        SHORT_SEL_RST  = 1'b1;
    typedef enum logic [2:0] {
        LEDFS_CHECK, LEDFS_RUN, LEDFS_HOT, LEDFS_LATCHED
    } ledfs_state_t;
endpackage : ledfs_pkg

//--- verilog/ledfs_supervisor.sv
/*
 * Fault supervisor: gates boost switching, channel enables and the input
 * protection switch from synchronised comparator flags.
 * Assumes all flags come from analog comparators (asynchronous to ref_clk)
 * and that the enable pin holds reset-like power down outside this block.
 */
module ledfs_supervisor #(
    parameter int unsigned  NUM_CH         = 8,
    parameter int unsigned  OPEN_SLOW_CYC  = ledfs_pkg::OPEN_SLOW_CYC,
    parameter int unsigned  OPEN_FAST_CYC  = ledfs_pkg::OPEN_FAST_CYC,
    parameter int unsigned  SHORT_FAST_CYC = ledfs_pkg::SHORT_FAST_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                supply_low_lockout,
    input  wire logic                switch_overcurrent,
    input  wire logic                switch_drive_req,
    input  wire logic                switch_node_above,
    input  wire logic                output_overvoltage_sense,
    input  wire logic                overvoltage_sense_low,
    input  wire logic                temp_lower_hot,
    input  wire logic                temp_upper_hot,
    input  wire logic                temp_cooled,
    input  wire logic [NUM_CH-1:0]   ch_good_level,
    input  wire logic [NUM_CH-1:0]   ch_half_level,
    input  wire logic [NUM_CH-1:0]   channel_sink_voltage_high,
    input  wire logic                short_sel_in,
    input  wire logic                short_detect_off,
    output logic                     boost_gate,
    output logic                     startup_inject,
    output logic                     protect_switch_on,
    output logic [NUM_CH-1:0]        channel_enable,
    output logic [7:0]               dc_scale,
    output logic                     short_threshold_level,
    output logic                     thermal_fault
);
    import ledfs_pkg::*;

    initial begin
        if (NUM_CH < 1 || NUM_CH > 16 || OPEN_FAST_CYC < 1 ||
            SHORT_FAST_CYC < 1 || OPEN_SLOW_CYC < OPEN_FAST_CYC)
            $error("ledfs_supervisor: unsupported parameters");
    end

    localparam int CW = $clog2(OPEN_SLOW_CYC + 1);
    localparam int NI = 11;

    // Two-stage synchronisers for every comparator input
    logic [NI+3*NUM_CH-1:0] raw_in, sync1_q, sync2_q;
    assign raw_in = {switch_overcurrent, switch_drive_req, switch_node_above,
                     output_overvoltage_sense, overvoltage_sense_low,
                     temp_lower_hot, temp_upper_hot, temp_cooled,
                     short_sel_in, short_detect_off, supply_low_lockout,
                     ch_good_level, ch_half_level, channel_sink_voltage_high};
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    logic s_oc, s_drv, s_lx, s_ovp, s_ovlow, s_tlo, s_thi, s_tcool;
    logic s_ssel, s_soff, s_uv;
    logic [NUM_CH-1:0] s_good, s_half, s_short;
    assign {s_oc, s_drv, s_lx, s_ovp, s_ovlow, s_tlo, s_thi, s_tcool,
            s_ssel, s_soff, s_uv, s_good, s_half, s_short} = sync2_q;

    typedef struct packed {
        ledfs_state_t          st;
        logic [4:0]            wait_cnt;
        logic                  ov_armed;
        logic                  protect;
        logic                  gate;
        logic                  inject;
        logic [NUM_CH-1:0]     good;
        logic [NUM_CH-1:0]     off;
        logic [NUM_CH-1:0][CW-1:0] open_cnt;
        logic [NUM_CH-1:0][CW-1:0] short_cnt;
        logic [1:0]            trips;
        logic                  tfault;
        logic                  ssel;
    } ledfs_reg_t;

    ledfs_reg_t r_q, r_d;

    function automatic logic [7:0] step_scale(input logic [1:0] n);
        case (n)
            2'd0:    step_scale = SCALE_FULL;
            2'd1:    step_scale = SCALE_STEP1;
            2'd2:    step_scale = SCALE_STEP2;
            default: step_scale = SCALE_STEP3;
        endcase
    endfunction : step_scale

    // Advance a time-out counter; clears when the fault goes away
    function automatic logic [CW-1:0] tick(input logic f,
                                           input logic [CW-1:0] c,
                                           input logic [CW-1:0] lim);
        if (!f)
            tick = '0;
        else if (c < lim)
            tick = c + 1'b1;
        else
            tick = c;
    endfunction : tick

    logic [CW-1:0] open_lim, short_lim;
    logic          running;
    assign open_lim  = s_tlo ? CW'(OPEN_FAST_CYC) : CW'(OPEN_SLOW_CYC);
    assign short_lim = s_tlo ? CW'(SHORT_FAST_CYC)
                             : CW'(OPEN_SLOW_CYC);
    assign running   = (r_q.st == LEDFS_RUN);

    always_comb begin
        logic open_f;
        logic short_f;
        open_f  = 1'b0;
        short_f = 1'b0;
        r_d = r_q;
        r_d.ssel   = s_ssel;
        r_d.inject = 1'b0;
        r_d.gate   = 1'b0;
        case (r_q.st)
            LEDFS_CHECK: begin
                r_d.inject = 1'b1;
                if (s_lx) begin
                    if (r_q.wait_cnt == 5'(STARTUP_WAIT_CYC)) begin
                        r_d.st      = LEDFS_RUN;
                        r_d.protect = 1'b1;
                        r_d.inject  = 1'b0;
                    end else begin
                        r_d.wait_cnt = r_q.wait_cnt + 5'd1;
                    end
                end else begin
                    r_d.wait_cnt = '0;
                end
            end
            LEDFS_RUN: begin
                // Gate off at once on overcurrent; retry next cycle
                r_d.gate = s_drv && !s_oc;
                if (s_ovp)
                    r_d.ov_armed = 1'b1;
                if ((!s_drv && !r_q.gate && !s_lx) ||
                    (r_q.ov_armed && s_ovlow)) begin
                    r_d.protect = 1'b0;
                    r_d.gate    = 1'b0;
                    r_d.st      = LEDFS_LATCHED;
                end else if (s_thi) begin
                    r_d.gate   = 1'b0;
                    r_d.tfault = 1'b1;
                    if (r_q.trips != 2'd3)
                        r_d.trips = r_q.trips + 2'd1;
                    r_d.st = LEDFS_HOT;
                end
            end
            LEDFS_HOT: begin
                if (s_tcool && !s_thi)
                    r_d.st = LEDFS_RUN;
            end
            LEDFS_LATCHED: begin
                // Shutdown holds until supply lockout resets the block
                r_d.protect = 1'b0;
            end
            default: r_d.st = LEDFS_CHECK;
        endcase
        r_d.tfault = r_d.tfault | s_thi;
        for (int i = 0; i < NUM_CH; i++) begin
            if (s_good[i])
                r_d.good[i] = 1'b1;
            // Zener channels stay "good" and are never timed out here
            open_f = running && !r_q.off[i] &&
                     ((r_q.good[i] && !s_half[i]) ||
                      ((s_tlo || s_ovp) && !r_q.good[i]) ||
                      ((s_tlo || s_ovp) && !s_half[i]));
            short_f = running && !r_q.off[i] && !s_soff &&
                      s_short[i];
            r_d.open_cnt[i]  = tick(open_f, r_q.open_cnt[i], open_lim);
            r_d.short_cnt[i] = tick(short_f, r_q.short_cnt[i], short_lim);
            // Only this channel drops; the rest are untouched
            if ((open_f && r_q.open_cnt[i] >= open_lim) ||
                (short_f && r_q.short_cnt[i] >= short_lim))
                r_d.off[i] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            r_q          <= '0;
            r_q.st       <= LEDFS_CHECK;
            r_q.ssel     <= SHORT_SEL_RST;
        end else if (s_uv) begin
            r_q          <= '0;
            r_q.st       <= LEDFS_CHECK;
            r_q.ssel     <= SHORT_SEL_RST;
        end else begin
            r_q <= r_d;
        end
    end

    logic [NUM_CH-1:0] en_q;
    logic [7:0]        scale_q;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            en_q    <= '0;
            scale_q <= SCALE_FULL;
        end else begin
            en_q    <= (r_d.st == LEDFS_RUN && !s_uv) ? ~r_d.off : '0;
            // Lockout must restore full current on the same edge
            scale_q <= s_uv ? SCALE_FULL
                            : step_scale(r_d.trips);
        end
    end

    assign boost_gate            = r_q.gate;
    assign startup_inject        = r_q.inject;
    assign protect_switch_on     = r_q.protect;
    assign channel_enable        = en_q;
    assign dc_scale              = scale_q;
    assign short_threshold_level = r_q.ssel;
    assign thermal_fault         = r_q.tfault;

    chk_gate_needs_run: assert property (@(posedge ref_clk) disable iff (reset)
        boost_gate |-> $past(r_q.st) == LEDFS_RUN)
        else $error("boost gate outside run");
    chk_oc_kills_gate: assert property (@(posedge ref_clk) disable iff (reset)
        s_oc |=> !boost_gate)
        else $error("gate stayed on under overcurrent");
    chk_hot_no_gate: assert property (@(posedge ref_clk) disable iff (reset)
        (running && s_thi && !s_uv) |=> !boost_gate && thermal_fault)
        else $error("upper trip did not stop boost");
    chk_hot_ch_off: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_HOT) |-> channel_enable == '0)
        else $error("channels on while hot");
    chk_uv_resets: assert property (@(posedge ref_clk) disable iff (reset)
        s_uv |=> r_q.st == LEDFS_CHECK && !protect_switch_on)
        else $error("lockout did not reset");
    chk_inject_start: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_CHECK && !s_uv && !s_lx) |=> startup_inject)
        else $error("no start-up injection");
    sequence ov_rise_fall;
        running && s_ovp ##1 (running && r_q.ov_armed && s_ovlow && !s_uv);
    endsequence
    chk_ov_collapse: assert property (@(posedge ref_clk) disable iff (reset)
        ov_rise_fall |=> !protect_switch_on)
        else $error("protect switch kept after collapse");
    chk_scale_step: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.trips == 2'd1) |=> dc_scale == SCALE_STEP1 || s_thi || s_uv)
        else $error("first trip scale wrong");
    chk_tfault_sticky: assert property (@(posedge ref_clk) disable iff (reset)
        (thermal_fault && !s_uv) |=> thermal_fault)
        else $error("thermal fault lost");

    // Lockout clears outputs, but full current comes back at once
    chk_uv_outputs: assert property (@(posedge ref_clk) disable iff (reset)
        s_uv |=> dc_scale == SCALE_FULL && channel_enable == '0 &&
                 !boost_gate && !thermal_fault)
        else $error("outputs not cleared by lockout");

    // Start-up: nothing switches before the node check has passed
    chk_no_early_prot: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_CHECK) |-> !protect_switch_on)
        else $error("protect switch on before node check");

    chk_check_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_CHECK) |->
            !boost_gate && channel_enable == '0)
        else $error("switching during start-up check");

    chk_inject_stops: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st != LEDFS_CHECK) |-> !startup_inject)
        else $error("injection outside start-up");

    // Gate follows the loop request whenever nothing forbids it
    chk_gate_follows: assert property (@(posedge ref_clk) disable iff (reset)
        (running && s_drv && !s_oc && !s_thi && !s_uv &&
         !(r_q.ov_armed && s_ovlow)) |=> boost_gate)
        else $error("gate withheld without a fault");

    // Protection switch faults latch until lockout
    chk_node_low_trip: assert property (@(posedge ref_clk) disable iff (reset)
        (running && !s_drv && !r_q.gate && !s_lx && !s_uv) |=>
            !protect_switch_on)
        else $error("node low did not drop protect switch");

    chk_latched_holds: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_LATCHED && !s_uv) |=>
            r_q.st == LEDFS_LATCHED && !protect_switch_on)
        else $error("latched shutdown released");

    chk_latched_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_LATCHED) |->
            !boost_gate && channel_enable == '0)
        else $error("switching after shutdown");

    chk_ov_arm: assert property (@(posedge ref_clk) disable iff (reset)
        (running && s_ovp && !s_uv) |=> r_q.ov_armed)
        else $error("overvoltage sense not armed");

    // Thermal cycle: hold while hot, restart once cooled
    sequence hot_waiting;
        r_q.st == LEDFS_HOT && !s_tcool && !s_uv;
    endsequence
    sequence hot_cooled;
        r_q.st == LEDFS_HOT && s_tcool && !s_thi && !s_uv;
    endsequence

    chk_hot_holds: assert property (@(posedge ref_clk) disable iff (reset)
        hot_waiting |=> r_q.st == LEDFS_HOT)
        else $error("left hot state before cooling");

    chk_hot_restart: assert property (@(posedge ref_clk) disable iff (reset)
        hot_cooled |=> r_q.st == LEDFS_RUN)
        else $error("no restart after cooling");

    chk_hot_protect: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_HOT) |-> protect_switch_on)
        else $error("supply cut during thermal fault");

    chk_scale_full: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.trips == 2'd0) |-> dc_scale == SCALE_FULL)
        else $error("scale reduced without a trip");

    chk_scale_second: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.trips == 2'd2) |-> dc_scale == SCALE_STEP2)
        else $error("second trip scale wrong");

    chk_scale_third: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.trips == 2'd3) |-> dc_scale == SCALE_STEP3)
        else $error("third trip scale wrong");

    // Channel bookkeeping: off and good never clear while powered
    chk_en_follows_off: assert property (@(posedge ref_clk) disable iff (reset)
        (r_q.st == LEDFS_RUN) |-> channel_enable == ~r_q.off)
        else $error("channel enable disagrees with faults");

    chk_off_sticky: assert property (@(posedge ref_clk) disable iff (reset)
        !s_uv |=> (r_q.off & $past(r_q.off)) == $past(r_q.off))
        else $error("faulted channel came back");

    chk_good_sticky: assert property (@(posedge ref_clk) disable iff (reset)
        !s_uv |=> (r_q.good & $past(r_q.good)) == $past(r_q.good))
        else $error("good mark lost");

    chk_short_disable: assert property (@(posedge ref_clk) disable iff (reset)
        s_soff |=> r_q.short_cnt == '0)
        else $error("short timer ran while disabled");

    chk_cnt_idle: assert property (@(posedge ref_clk) disable iff (reset)
        !running |=> r_q.open_cnt == '0 && r_q.short_cnt == '0)
        else $error("fault timer ran outside run");

    chk_ssel_follow: assert property (@(posedge ref_clk) disable iff (reset)
        !s_uv |=> short_threshold_level == $past(s_ssel))
        else $error("threshold select not passed on");
endmodule : ledfs_supervisor

//--- verification/ledfs_host_model.sv
/*
 * Host-side model: polls the thermal fault status as a processor would.
 * Assumes it shares ref_clk and reset with the supervisor.
 */
module ledfs_host_model (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       thermal_fault,
    output logic            status_fault,
    output logic [7:0]      trip_events
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_q;
    // Status stays readable through thermal events
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prev_q       <= 1'b0;
            status_fault <= 1'b0;
            trip_events  <= 8'h00;
        end else begin
            prev_q       <= thermal_fault;
            status_fault <= thermal_fault;
            if (thermal_fault && !prev_q) begin
                trip_events <= trip_events + 8'h01;
            end
        end
    end
endmodule : ledfs_host_model

//--- verification/tb_top.sv
/*
 * Self-checking bench for the fault supervisor with shortened time-outs.
 * Assumes a 125 MHz ref_clk and comparator levels driven 1 ns after edges.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, lockout, ovc, drive, node_hi, ov_sense, ov_low;
    logic t_low, t_up, t_cool, sel, sc_off;
    logic [7:0] good, half, sink_hi, ch_en, scale, trips;
    logic gate, inject, protect, sc_lvl, tfault, host_fault;
    int n_errors, n_compared, cycles, k;

    ledfs_supervisor #(.OPEN_SLOW_CYC(40), .OPEN_FAST_CYC(10),
        .SHORT_FAST_CYC(8)) i_ledfs_supervisor (
        .ref_clk(ref_clk), .reset(reset), .supply_low_lockout(lockout),
        .switch_overcurrent(ovc), .switch_drive_req(drive),
        .switch_node_above(node_hi), .output_overvoltage_sense(ov_sense),
        .overvoltage_sense_low(ov_low), .temp_lower_hot(t_low),
        .temp_upper_hot(t_up), .temp_cooled(t_cool), .ch_good_level(good),
        .ch_half_level(half), .channel_sink_voltage_high(sink_hi),
        .short_sel_in(sel), .short_detect_off(sc_off), .boost_gate(gate),
        .startup_inject(inject), .protect_switch_on(protect),
        .channel_enable(ch_en), .dc_scale(scale),
        .short_threshold_level(sc_lvl), .thermal_fault(tfault));
    ledfs_host_model i_ledfs_host_model (.ref_clk(ref_clk), .reset(reset),
        .thermal_fault(tfault), .status_fault(host_fault),
        .trip_events(trips));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask : check
    task automatic close_out();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic start_up();
        check("inject", {7'h0, inject}, 8'h01);
        check("protect early", {7'h0, protect}, 8'h00);
        node_hi = 1'b1;
        for (k = 0; k < 40 && protect !== 1'b1; k++) step(1);
        check("protect on", {7'h0, protect}, 8'h01);
        check("inject off", {7'h0, inject}, 8'h00);
        step(3);
        check("channels on", ch_en, 8'hff);
    endtask : start_up
    task automatic gate_test();
        drive = 1'b1;
        step(4);
        check("gate on", {7'h0, gate}, 8'h01);
        ovc = 1'b1;
        step(4);
        check("gate limit", {7'h0, gate}, 8'h00);
        ovc = 1'b0;
        step(4);
        check("gate resume", {7'h0, gate}, 8'h01);
    endtask : gate_test
    task automatic open_test();
        half[3] = 1'b0;
        step(20);
        half[3] = 1'b1;
        step(5);
        half[3] = 1'b0;
        step(30);
        check("open restart", ch_en, 8'hff);
        step(20);
        check("open off", ch_en, 8'hf7);
        half[3] = 1'b1;
    endtask : open_test
    task automatic short_test();
        t_low = 1'b1;
        step(4);
        sc_off = 1'b1;
        sink_hi[6] = 1'b1;
        step(20);
        check("sc disabled", {7'h0, ch_en[6]}, 8'h01);
        sink_hi[6] = 1'b0;
        sc_off = 1'b0;
        step(4);
        sink_hi[5] = 1'b1;
        for (k = 0; k < 40 && ch_en[5] !== 1'b0; k++) step(1);
        check("short fast", {7'h0, k >= 8 && k <= 14}, 8'h01);
        check("short off", ch_en, 8'hd7);
        t_low = 1'b0;
        sink_hi[5] = 1'b0;
        sel = 1'b0;
        step(4);
        check("sc level", {7'h0, sc_lvl}, 8'h00);
    endtask : short_test
    task automatic thermal_test(input logic [7:0] exp_scale);
        t_up = 1'b1;
        step(6);
        check("hot gate", {7'h0, gate}, 8'h00);
        check("hot ch", ch_en, 8'h00);
        check("tfault", {7'h0, tfault}, 8'h01);
        t_up = 1'b0;
        t_cool = 1'b1;
        step(6);
        t_cool = 1'b0;
        check("scale", scale, exp_scale);
        check("host", {7'h0, host_fault}, 8'h01);
    endtask : thermal_test

    initial begin
        {lockout, ovc, drive, node_hi, ov_sense, ov_low} = 6'h00;
        {t_low, t_up, t_cool, sc_off} = 4'h0;
        sel = 1'b1;
        good = 8'hff;
        half = 8'hff;
        sink_hi = 8'h00;
        reset = 1'b1;
        step(15);
        check("rst scale", scale, 8'hff);
        check("rst sc", {7'h0, sc_lvl}, 8'h01);
        check("rst out", {gate, inject, protect, tfault, 4'h0}, 8'h00);
        step(1);
        reset = 1'b0;
        step(4);
        start_up();
        gate_test();
        open_test();
        short_test();
        thermal_test(8'hc4);
        thermal_test(8'h87);
        thermal_test(8'h4d);
        thermal_test(8'h4d);
        check("trips", trips, 8'h01);
        drive = 1'b0;
        node_hi = 1'b0;
        step(6);
        check("node low", {7'h0, protect}, 8'h00);
        lockout = 1'b1;
        step(6);
        check("lock scale", scale, 8'hff);
        check("lock out", {gate, protect, tfault, 5'h0}, 8'h00);
        lockout = 1'b0;
        step(4);
        start_up();
        // Sense must first rise above the level before the collapse counts
        ov_sense = 1'b1;
        step(4);
        check("ov kept", {7'h0, protect}, 8'h01);
        ov_sense = 1'b0;
        ov_low = 1'b1;
        step(6);
        check("ov drop", {7'h0, protect}, 8'h00);
        close_out();
    end
endmodule : tb_top
